/* File: hdl/mtap_access_policy.sv */
`timescale 1ns/100ps

// Operation
// - Normal reads may be reissued; target is side-effect free.
// - Normal regions may be prefetched ahead of demand.
// - Normal writes reissued only while location is unchanged.
// - Misaligned accesses to Normal memory are passed through.
// - Normal accesses may be merged into fewer transactions.
// - Writable/read-only (Normal regions only) and shareable attributes are honoured.
// - Non-shareable Normal needs no hardware-coherent caching.
// - Non-shareable exclusive monitoring considers only the local processor.
// - Shareable Normal caching must be invisible to all observers.
// - Shareable exclusive monitoring covers every observer in the domain.
// - Shareable coherency met by not caching or by hardware coherency.
// - Each Normal region has exactly one cacheability class.
// - Cacheability decoded apart from shareability; shareable may stay uncached.
// - Device accesses keep program size and program count.
// - Device accesses are never issued twice.
// - No speculative access to Device regions.
// - Device regions are non-cacheable, no lookup or allocation.
// - Device writes buffered; merging keeps count, order and size.
// - Repeated Device accesses to one address are never coalesced.
// - Interrupted multi-access instructions may be restarted and repeat accesses.
// - Misaligned Device accesses are refused as unsupported.
// - Device regions carry shareability; non-shareable stays local.
// - Aligned byte, halfword and word accesses are single transfers.
module mtap_access_policy #(
  parameter bit SHARE_COHERENT = 1'b0
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire logic               req_valid,
  input  mtap_pkg::mtap_req_t     req,
  input  mtap_pkg::mtap_attr_t    req_attr,
  input  wire logic               restart,
  input  wire logic               merge_en,
  input  wire logic               prefetch_en,
  input  wire logic               mem_ready,
  output logic                    req_ready,
  output logic                    txn_valid,
  output mtap_pkg::mtap_txn_t     txn,
  output logic                    fault_valid,
  output mtap_pkg::mtap_fault_t   fault,
  output logic                    dev_issue_done
);
  import mtap_pkg::*;

  // ==========================================================================
  // Request classification
  logic       is_dev;
  logic       misaligned;
  logic       cacheable;
  logic       ro_hit;
  logic       take;
  logic       can_merge;
  logic       do_pf;
  mtap_txn_t  txn_next;
  mtap_txn_t  pf_txn;
  logic       pf_cacheable;
  mtap_fault_t fault_next;

  // Device issue tracking: one outstanding device access, never replayed
  logic               dev_busy_reg;
  logic [MTAP_AW-1:0] last_waddr_reg;
  logic               last_wvalid_reg;
  logic [MTAP_AW-1:0] pf_addr_reg;
  logic               pf_pend_reg;
  mtap_attr_t         pf_attr_reg;

  always_comb begin
    is_dev     = (req_attr.mtype == MTAP_MT_DEVICE);
    unique case (req.size)
      MTAP_SZ_HALF: misaligned = |(req.addr[1:0] & MTAP_HALF_MASK);
      MTAP_SZ_WORD: misaligned = |(req.addr[1:0] & MTAP_WORD_MASK);
      default:      misaligned = 1'b0;
    endcase
    // Shareable data stays uncached unless hardware coherency exists
    cacheable  = !is_dev && (req_attr.cclass != MTAP_CC_NONCACHE)
                 && (!req_attr.shareable || SHARE_COHERENT);
    ro_hit     = req.write && !req_attr.writable && !is_dev;
    fault_next.ro_write      = ro_hit;
    fault_next.dev_unaligned = is_dev && misaligned;
    fault_next.dev_spec      = is_dev && req.spec;
  end

  // A request is taken only when the output slot is free
  always_comb begin
    req_ready = ce && !(txn_valid && !mem_ready) && !dev_busy_reg && !pf_pend_reg;
    take      = req_valid && req_ready;
  end

  // Merging only for consecutive Normal words of a multi-access write
  always_comb begin
    can_merge = merge_en && !is_dev && req.write && req.multi
                && last_wvalid_reg && (req.addr == last_waddr_reg + MTAP_WORD_BYTES)
                && (req.size == MTAP_SZ_WORD);
    do_pf     = prefetch_en && !is_dev && !req.write && !req.excl;
  end

  always_comb begin
    txn_next              = '0;
    txn_next.addr         = req.addr;
    txn_next.wdata        = req.wdata;
    txn_next.size         = req.size;
    txn_next.write        = req.write;
    txn_next.excl         = req.excl;
    txn_next.atomic       = !misaligned;
    txn_next.cache_lookup = cacheable;
    txn_next.cache_alloc  = cacheable && (!req.write || req_attr.cclass == MTAP_CC_WB_WA);
    txn_next.coherent     = req_attr.shareable && !is_dev;
    txn_next.excl_global  = req.excl && req_attr.shareable;
    txn_next.merged       = can_merge;
    txn_next.attr         = req_attr;
  end

  // Prefetch of the next word, Normal only; an extra read there has no side effect
  always_comb begin
    pf_cacheable        = (pf_attr_reg.cclass != MTAP_CC_NONCACHE)
                          && (!pf_attr_reg.shareable || SHARE_COHERENT);
    pf_txn              = '0;
    pf_txn.addr         = pf_addr_reg;
    pf_txn.size         = MTAP_SZ_WORD;
    pf_txn.prefetch     = 1'b1;
    pf_txn.atomic       = 1'b1;
    pf_txn.cache_lookup = pf_cacheable;
    pf_txn.cache_alloc  = pf_cacheable;
    pf_txn.coherent     = pf_attr_reg.shareable;
    pf_txn.attr         = pf_attr_reg;
  end

  // ==========================================================================
  // Output transaction register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txn_valid <= 1'b0;
      txn       <= '0;
    end else if (ce) begin
      if (take && !(|fault_next)) begin
        txn_valid <= 1'b1;
        txn       <= txn_next;
      end else if (pf_pend_reg && (!txn_valid || mem_ready)) begin
        txn_valid <= 1'b1;
        txn       <= pf_txn;
      end else if (mem_ready) begin
        txn_valid <= 1'b0;
      end
    end
  end

  // Pending prefetch, queued behind a Normal demand read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pf_pend_reg <= 1'b0;
      pf_addr_reg <= '0;
      pf_attr_reg <= '0;
    end else if (ce) begin
      if (take && !(|fault_next) && do_pf) begin
        pf_pend_reg <= 1'b1;
        pf_addr_reg <= {req.addr[MTAP_AW-1:2], 2'h0} + MTAP_WORD_BYTES;
        pf_attr_reg <= req_attr;
      end else if (pf_pend_reg && (!txn_valid || mem_ready)) begin
        pf_pend_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Merge tracking; a restart breaks the chain so replayed words stand alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_wvalid_reg <= 1'b0;
      last_waddr_reg  <= '0;
    end else if (ce) begin
      if (restart) begin
        last_wvalid_reg <= 1'b0;
      end else if (take) begin
        last_wvalid_reg <= req.write && req.multi && !is_dev && !(|fault_next);
        last_waddr_reg  <= req.addr;
      end
    end
  end

  // ==========================================================================
  // Device access holds until accepted; never reissued on its own
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dev_busy_reg   <= 1'b0;
      dev_issue_done <= 1'b0;
    end else if (ce) begin
      dev_issue_done <= 1'b0;
      if (take && is_dev && !(|fault_next)) begin
        dev_busy_reg <= 1'b1;
      end else if (dev_busy_reg && txn_valid && mem_ready) begin
        dev_busy_reg   <= 1'b0;
        dev_issue_done <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Refusals
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_valid <= 1'b0;
      fault       <= '0;
    end else if (ce) begin
      fault_valid <= take && (|fault_next);
      fault       <= take ? fault_next : '0;
    end
  end

endmodule

/* File: hdl/mtap_pkg.sv */
package mtap_pkg;

  // ==========================================================================
  // Memory type encodings
  typedef enum logic [1:0] {
    MTAP_MT_NORMAL = 2'h0,
    MTAP_MT_DEVICE = 2'h1
  } mtap_mtype_t;

  typedef enum logic [1:0] {
    MTAP_CC_NONCACHE = 2'h0,
    MTAP_CC_WT       = 2'h1,
    MTAP_CC_WB_WA    = 2'h2,
    MTAP_CC_WB_NOWA  = 2'h3
  } mtap_cclass_t;

  typedef enum logic [1:0] {
    MTAP_SZ_BYTE = 2'h0,
    MTAP_SZ_HALF = 2'h1,
    MTAP_SZ_WORD = 2'h2
  } mtap_size_t;

  localparam int unsigned MTAP_AW = 32;
  localparam int unsigned MTAP_DW = 32;
  localparam logic [1:0] MTAP_HALF_MASK = 2'h1;
  localparam logic [1:0] MTAP_WORD_MASK = 2'h3;
  localparam logic [1:0] MTAP_WORD_STEP = 2'h1;
  localparam logic [1:0] MTAP_NEXT_WORD_INC = 2'h0;
  localparam logic [MTAP_AW-1:0] MTAP_WORD_BYTES = 32'h0000_0004;

  // ==========================================================================
  // Region attributes, supplied by the region lookup
  typedef struct packed {
    mtap_mtype_t  mtype;
    logic         shareable;
    logic         writable;
    mtap_cclass_t cclass;
  } mtap_attr_t;

  // Request from the load/store unit
  typedef struct packed {
    logic [MTAP_AW-1:0] addr;
    logic [MTAP_DW-1:0] wdata;
    mtap_size_t         size;
    logic               write;
    logic               spec;
    logic               excl;
    logic               multi;
  } mtap_req_t;

  // Transaction presented to the memory system
  typedef struct packed {
    logic [MTAP_AW-1:0] addr;
    logic [MTAP_DW-1:0] wdata;
    mtap_size_t         size;
    logic               write;
    logic               excl;
    logic               atomic;
    logic               cache_alloc;
    logic               cache_lookup;
    logic               coherent;
    logic               excl_global;
    logic               prefetch;
    logic               merged;
    mtap_attr_t         attr;
  } mtap_txn_t;

  // Reasons an access is refused
  typedef struct packed {
    logic ro_write;
    logic dev_unaligned;
    logic dev_spec;
  } mtap_fault_t;

endpackage

/* File: tb/mtap_access_policy_tb.sv */
`timescale 1ns/100ps

// ==========================================
// Sequence of requests with expected outcomes
module mtap_access_policy_tb;
  import mtap_pkg::*;
  logic        clk, rst, ce, req_valid, restart, merge_en, prefetch_en, slow;
  logic        mem_ready, req_ready, txn_valid, fault_valid, dev_issue_done, gv, gfv, pv;
  mtap_req_t   req;
  mtap_attr_t  req_attr, at;
  mtap_txn_t   txn, got, pf;
  mtap_fault_t fault, gf;
  int          n_errors = 0, n_checks = 0, n_done = 0, n0;

  mtap_access_policy mtap_access_policy_i (.clk, .rst, .ce, .req_valid, .req, .req_attr,
    .restart, .merge_en, .prefetch_en, .mem_ready, .req_ready, .txn_valid, .txn,
    .fault_valid, .fault, .dev_issue_done);
  mtap_mem_model mtap_mem_model_i (.clk, .rst, .slow, .mem_ready);

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  always @(negedge clk) if (dev_issue_done === 1'h1) n_done++;

  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Flags f are write, speculative, exclusive, multi; answer lands one cycle after the take
  task automatic op(input logic [31:0] a, input mtap_size_t s, input logic [3:0] f,
                    input mtap_attr_t ta);
    int i;
    @(posedge clk);
    req <= '{a, ~a, s, f[3], f[2], f[1], f[0]};
    req_attr <= ta;
    req_valid <= 1'h1;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (req_ready !== 1'h1 && i < 40);
    if (req_ready !== 1'h1) begin
      n_errors++;
      $display("MISMATCH t=%0t request never taken", $time);
      report_and_stop;
    end
    @(posedge clk);
    req_valid <= 1'h0;
    req <= mtap_req_t'(~req);
    @(negedge clk);
    got = txn; gv = txn_valid; gfv = fault_valid; gf = fault;
    @(negedge clk);
    pf = txn; pv = txn_valid;
  endtask

  initial begin
    rst = 1'h1; ce = 1'h1; req_valid = 1'h0; restart = 1'h0; slow = 1'h0;
    merge_en = 1'h0; prefetch_en = 1'h1; req = '0; req_attr = '0;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    at = '{MTAP_MT_DEVICE, 1'h0, 1'h1, MTAP_CC_WB_WA};
    op(32'h4000_0010, MTAP_SZ_WORD, 4'h0, at);
    chk(got.addr, 32'h4000_0010);
    chk(got.attr, at);
    chk(got.cache_lookup, 1'h0);
    chk(got.atomic, 1'h1);
    chk(pv, 1'h0);
    op(32'h4000_0010, MTAP_SZ_WORD, 4'h4, at);
    chk({gv, gfv, gf.dev_spec}, 3'h3);
    op(32'h4000_0012, MTAP_SZ_WORD, 4'h0, at);
    chk({gv, gfv, gf.dev_unaligned}, 3'h3);
    slow = 1'h1;
    n0 = n_done;
    repeat (2) op(32'h4000_0020, MTAP_SZ_HALF, 4'h8, at);
    // Idle gap stands in for the barrier before Normal traffic resumes
    repeat (6) @(negedge clk);
    slow = 1'h0;
    chk(n_done - n0, 2);
    for (int c = 0; c < 4; c++) begin
      at = '{MTAP_MT_NORMAL, 1'h0, 1'h1, mtap_cclass_t'(c)};
      op(32'h0000_0106, MTAP_SZ_HALF, 4'h0, at);
      chk(got.addr, 32'h0000_0106);
      chk(got.cache_lookup, c != 0);
      chk(got.cache_alloc, c != 0);
      chk({pv, pf.prefetch}, 2'h3);
      chk(pf.addr, 32'h0000_0108);
    end
    for (int sh = 0; sh < 2; sh++) begin
      at = '{MTAP_MT_NORMAL, sh[0], 1'h1, MTAP_CC_WB_WA};
      op(32'h0000_0200, MTAP_SZ_WORD, 4'h2, at);
      chk(got.excl_global, sh);
      chk(got.coherent, sh);
      chk(got.cache_lookup, sh == 0);
    end
    op(32'h0000_0301, MTAP_SZ_WORD, 4'h0, at);
    chk({gv, got.atomic}, 2'h2);
    at = '{MTAP_MT_NORMAL, 1'h0, 1'h0, MTAP_CC_WT};
    op(32'h0000_0300, MTAP_SZ_WORD, 4'h8, at);
    chk({gv, gf.ro_write}, 2'h1);
    at.writable = 1'h1;
    @(posedge clk) merge_en <= 1'h1;
    op(32'h0000_0400, MTAP_SZ_WORD, 4'h9, at);
    op(32'h0000_0404, MTAP_SZ_WORD, 4'h9, at);
    chk({gv, got.merged}, 2'h3);
    chk(got.wdata, 32'hffff_fbfb);
    chk({got.cache_lookup, got.cache_alloc}, 2'h2);
    @(posedge clk) restart <= 1'h1;
    @(posedge clk) restart <= 1'h0;
    op(32'h0000_0408, MTAP_SZ_WORD, 4'h9, at);
    chk({gv, got.merged}, 2'h2);
    report_and_stop;
  end
endmodule

/* File: tb/mtap_checker.sv */
`timescale 1ns/100ps

// ==========================================
// Port checks on the access policy
module mtap_checker #(
  parameter bit SHARE_COHERENT = 1'b0
) (
  input wire logic            clk,
  input wire logic            rst,
  input wire logic            req_valid,
  input wire logic            req_ready,
  input mtap_pkg::mtap_req_t  req,
  input mtap_pkg::mtap_attr_t req_attr,
  input wire logic            mem_ready,
  input wire logic            txn_valid,
  input mtap_pkg::mtap_txn_t  txn,
  input wire logic            fault_valid,
  input mtap_pkg::mtap_fault_t fault,
  input wire logic            dev_issue_done
);
  import mtap_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic take, dev, mis, bad, tdev;
  assign take = req_valid && req_ready;
  assign dev = req_attr.mtype == MTAP_MT_DEVICE;
  assign mis = (req.size == MTAP_SZ_HALF) ? req.addr[0] :
               (req.size == MTAP_SZ_WORD) && (|req.addr[1:0]);
  assign bad = dev ? (mis || req.spec) : (req.write && !req_attr.writable);
  assign tdev = txn_valid && txn.attr.mtype == MTAP_MT_DEVICE;
  sequence dev_take_s; take && dev && !bad; endsequence
  sequence dev_acc_s; tdev && mem_ready; endsequence

  ro_write_a: assert property (take && !dev && req.write && !req_attr.writable
    |=> fault_valid && fault.ro_write && !txn_valid) else $error("ro write passed");
  dev_spec_a: assert property (take && dev && req.spec
    |=> fault_valid && fault.dev_spec && !txn_valid) else $error("spec device passed");
  dev_unal_a: assert property (take && dev && mis
    |=> fault_valid && fault.dev_unaligned && !txn_valid) else $error("unaligned passed");
  dev_size_a: assert property (dev_take_s |=> txn_valid && txn.size == $past(req.size)
    && txn.addr == $past(req.addr)) else $error("device size or addr");
  dev_once_a: assert property (dev_acc_s |=> dev_issue_done && !tdev)
    else $error("device issued again");
  dev_nocache_a: assert property (tdev |-> !(txn.cache_lookup || txn.cache_alloc
    || txn.prefetch || txn.merged)) else $error("device cached");
  attr_carry_a: assert property (take && !bad |=> txn_valid && txn.attr == $past(req_attr))
    else $error("attr lost");
  share_nc_a: assert property (txn_valid && txn.attr.shareable && !SHARE_COHERENT
    |-> !txn.cache_lookup) else $error("shareable cached");
  excl_scope_a: assert property (txn_valid && txn.excl
    |-> txn.excl_global == txn.attr.shareable) else $error("excl scope");
  txn_hold_a: assert property (txn_valid && !mem_ready |=> txn_valid && $stable(txn))
    else $error("txn dropped");
  pf_normal_a: assert property (txn_valid && txn.prefetch
    |-> txn.attr.mtype == MTAP_MT_NORMAL && !txn.write) else $error("device prefetched");
endmodule

bind mtap_access_policy mtap_checker #(.SHARE_COHERENT(SHARE_COHERENT)) mtap_checker_i (
  .clk, .rst, .req_valid, .req_ready, .req, .req_attr, .mem_ready, .txn_valid, .txn,
  .fault_valid, .fault, .dev_issue_done);

/* File: tb/mtap_mem_model.sv */
`timescale 1ns/100ps

// ==========================================
// Memory side: prompt, or stalling three of four cycles
module mtap_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  output logic     mem_ready
);
  logic [1:0] wait_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_reg <= 2'h0;
    end else begin
      wait_reg <= wait_reg + 2'h1;
    end
  end

  // Slow mode stretches every hold so held-transaction checks get exercised
  assign mem_ready = !slow || (wait_reg == 2'h3);
endmodule
